// [logic/srl_boot_loader.sv]
// serial boot command handler: matching, baud change, ram loader, halt
// Function
// - after flash sum, await new command
// - echo valid ram loader command
// - bad command: code three times, halt
// - error codes sent exactly three times
// - echo matching byte, echo baud byte
// - two password addresses, high first, silent
// - blank password region skips comparison
// - bad password address halts silently
// - security enabled or mismatch halts
// - receive error in password phase halts
// - discard bytes until start mark
// - parse record, store payload in ram
// - sum after clean end record, upper first
// - record or receive error halts silently
// - jump to first data record address
// - new baud only after echo sent
`timescale 1ns/100ps
`default_nettype none
module srl_boot_loader
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // uart receiver, same clock
    input  wire logic                 rxValid,
    input  wire srl_pkg::srl_rx_s     rxByte,
    // uart transmitter, same clock
    output logic                      txValid,
    output logic [7:0]                txData,
    input  wire logic                 txReady,
    // baud rate control
    output logic                      baudLoad,
    output logic [7:0]                baudCode,
    // password store lookup, answer next cycle
    output logic                      pwRdEn,
    output srl_pkg::srl_rd_s          pwRd,
    input  wire logic [7:0]           pwRdData,
    input  wire logic                 pwBlank,
    input  wire logic                 securityOn,
    // ram write port
    output logic                      ramWrEn,
    output srl_pkg::srl_ram_wr_s      ramWr,
    // sum engine, started at end record
    output logic                      sumStart,
    input  wire logic                 sumDone,
    input  wire logic [15:0]          sumValue,
    // execution hand-off
    output logic                      jumpValid,
    output logic [15:0]               jumpAddr,
    output logic                      halted
);
    typedef enum logic [4:0] {
        S_MATCH, S_ECHO_MATCH, S_BAUD, S_ECHO_BAUD, S_CMD, S_ECHO_CMD,
        S_PWADDR, S_PWCNT_RD, S_PWCNT, S_PWSTR_RD, S_PWSTR,
        S_HUNT, S_LEN, S_ADDR, S_TYPE, S_PAYLOAD, S_CKSUM,
        S_SUM_WAIT, S_SUM_HI, S_SUM_LO, S_JUMP, S_ERR, S_HALT
    } srl_state_e;

    srl_state_e  state_ff;
    logic [7:0]  latch_ff;
    logic [1:0]  idx_ff;
    logic [15:0] cntAddr_ff;
    logic [15:0] cmpAddr_ff;
    logic [7:0]  pwLeft_ff;
    logic [7:0]  recLen_ff;
    logic [15:0] recAddr_ff;
    logic [7:0]  recType_ff;
    logic [7:0]  recSum_ff;
    logic [15:0] sum_ff;
    logic        firstSeen_ff;
    logic [15:0] firstAddr_ff;
    logic [7:0]  errCode_ff;
    logic        errStart;
    logic        errTxValid;
    logic [7:0]  errTxData;
    logic        errDone;

    function automatic logic isBaud(input logic [7:0] b);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < srl_pkg::NUM_BAUD; i++)
            if (b == srl_pkg::BAUD_CODES[i])
                hit = 1'b1;
        return hit;
    endfunction

    function automatic logic isCmd(input logic [7:0] b);
        return b == srl_pkg::CMD_FLASH || b == srl_pkg::CMD_RAMLOAD
            || b == srl_pkg::CMD_SUMOUT || b == srl_pkg::CMD_PRODID;
    endfunction

    logic rxErr;
    assign rxErr = rxByte.overrun || rxByte.framing;

    srl_err_sender u_err
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .start   (errStart),
        .code    (errCode_ff),
        .txValid (errTxValid),
        .txData  (errTxData),
        .txReady (txReady),
        .done    (errDone)
    );

    // main sequence
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_ff   <= S_MATCH;
            latch_ff   <= 8'h00;
            idx_ff     <= 2'd0;
            cntAddr_ff <= 16'h0000;
            cmpAddr_ff <= 16'h0000;
            pwLeft_ff  <= 8'h00;
            errCode_ff <= 8'h00;
        end
        else
        begin
            unique case (state_ff)
                S_MATCH:
                    // unrecognised bytes just wait for the next try
                    if (rxValid && !rxErr && rxByte.data == srl_pkg::MATCH_BYTE)
                        state_ff <= S_ECHO_MATCH;
                S_ECHO_MATCH:
                    if (txReady)
                        state_ff <= S_BAUD;
                S_BAUD:
                    if (rxValid)
                    begin
                        latch_ff <= rxByte.data;
                        if (rxByte.overrun)
                        begin
                            errCode_ff <= srl_pkg::ERR_OVERRUN;
                            state_ff   <= S_ERR;
                        end
                        else if (rxByte.framing)
                        begin
                            errCode_ff <= srl_pkg::ERR_FRAMING;
                            state_ff   <= S_ERR;
                        end
                        else if (!isBaud(rxByte.data))
                        begin
                            errCode_ff <= srl_pkg::ERR_BAUD;
                            state_ff   <= S_ERR;
                        end
                        else
                            state_ff <= S_ECHO_BAUD;
                    end
                S_ECHO_BAUD:
                    if (txReady)
                        state_ff <= S_CMD;
                S_CMD:
                    if (rxValid)
                    begin
                        latch_ff <= rxByte.data;
                        if (rxByte.overrun)
                        begin
                            errCode_ff <= srl_pkg::ERR_OVERRUN;
                            state_ff   <= S_ERR;
                        end
                        else if (rxByte.framing)
                        begin
                            errCode_ff <= srl_pkg::ERR_FRAMING;
                            state_ff   <= S_ERR;
                        end
                        else if (!isCmd(rxByte.data))
                        begin
                            errCode_ff <= srl_pkg::ERR_COMMAND;
                            state_ff   <= S_ERR;
                        end
                        else
                            state_ff <= S_ECHO_CMD;
                    end
                S_ECHO_CMD:
                    // only the ram loader continues; other modes live elsewhere
                    if (txReady)
                    begin
                        idx_ff   <= 2'd0;
                        state_ff <= (latch_ff == srl_pkg::CMD_RAMLOAD) ? S_PWADDR : S_CMD;
                    end
                S_PWADDR:
                    if (rxValid)
                    begin
                        if (rxErr)
                            state_ff <= S_HALT;
                        else
                        begin
                            idx_ff <= idx_ff + 2'd1;
                            if (idx_ff[1])
                                cmpAddr_ff <= {cmpAddr_ff[7:0], rxByte.data};
                            else
                                cntAddr_ff <= {cntAddr_ff[7:0], rxByte.data};
                            if (idx_ff == 2'd3)
                                state_ff <= securityOn ? S_HALT :
                                            pwBlank ? S_HUNT : S_PWCNT_RD;
                        end
                    end
                S_PWCNT_RD:
                    state_ff <= S_PWCNT;
                S_PWCNT:
                begin
                    pwLeft_ff <= pwRdData;
                    // an empty count means the address was wrong
                    state_ff  <= (pwRdData == 8'h00 || pwRdData == srl_pkg::ERASED_BYTE)
                                 ? S_HALT : S_PWSTR_RD;
                end
                S_PWSTR_RD:
                    if (rxValid)
                    begin
                        latch_ff <= rxByte.data;
                        state_ff <= rxErr ? S_HALT : S_PWSTR;
                    end
                S_PWSTR:
                begin
                    cmpAddr_ff <= cmpAddr_ff + 16'h0001;
                    pwLeft_ff  <= pwLeft_ff - 8'h01;
                    if (pwRdData != latch_ff)
                        state_ff <= S_HALT;
                    else
                        state_ff <= (pwLeft_ff == 8'h01) ? S_HUNT : S_PWSTR_RD;
                end
                S_HUNT:
                    if (rxValid && (rxErr || rxByte.data == srl_pkg::START_MARK))
                    begin
                        idx_ff   <= 2'd0;
                        state_ff <= rxErr ? S_HALT : S_LEN;
                    end
                S_LEN, S_ADDR, S_TYPE, S_PAYLOAD, S_CKSUM:
                    if (rxValid)
                    begin
                        if (rxErr)
                            state_ff <= S_HALT;
                        else
                            unique case (state_ff)
                                S_LEN:
                                    state_ff <= S_ADDR;
                                S_ADDR:
                                begin
                                    idx_ff <= idx_ff + 2'd1;
                                    if (idx_ff == 2'd1)
                                        state_ff <= S_TYPE;
                                end
                                S_TYPE:
                                    if (rxByte.data != srl_pkg::REC_DATA
                                        && rxByte.data != srl_pkg::REC_END)
                                        state_ff <= S_HALT;
                                    else
                                        state_ff <= (recLen_ff == 8'h00) ? S_CKSUM : S_PAYLOAD;
                                S_PAYLOAD:
                                    if (recLen_ff == 8'h01)
                                        state_ff <= S_CKSUM;
                                default:
                                    if (recSum_ff + rxByte.data != 8'h00)
                                        state_ff <= S_HALT;
                                    else if (recType_ff == srl_pkg::REC_END)
                                        state_ff <= S_SUM_WAIT;
                                    else
                                        state_ff <= S_HUNT;
                            endcase
                    end
                S_SUM_WAIT:
                    if (sumDone)
                        state_ff <= S_SUM_HI;
                S_SUM_HI:
                    if (txReady)
                        state_ff <= S_SUM_LO;
                S_SUM_LO:
                    if (txReady)
                        state_ff <= S_JUMP;
                S_JUMP:
                    state_ff <= S_HALT;
                S_ERR:
                    if (errDone)
                        state_ff <= S_HALT;
                S_HALT:
                    state_ff <= S_HALT;
                default:
                    state_ff <= S_HALT;
            endcase
        end
    end

    // record fields and first jump target
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            recLen_ff    <= 8'h00;
            recAddr_ff   <= 16'h0000;
            recType_ff   <= 8'h00;
            recSum_ff    <= 8'h00;
            firstSeen_ff <= 1'b0;
            firstAddr_ff <= 16'h0000;
            sum_ff       <= 16'h0000;
        end
        else
        begin
            if (rxValid && !rxErr)
            begin
                unique case (state_ff)
                    S_LEN:
                    begin
                        recLen_ff <= rxByte.data;
                        recSum_ff <= rxByte.data;
                    end
                    S_ADDR:
                    begin
                        recAddr_ff <= {recAddr_ff[7:0], rxByte.data};
                        recSum_ff  <= recSum_ff + rxByte.data;
                    end
                    S_TYPE:
                    begin
                        recType_ff <= rxByte.data;
                        recSum_ff  <= recSum_ff + rxByte.data;
                        if (!firstSeen_ff && rxByte.data == srl_pkg::REC_DATA)
                        begin
                            firstSeen_ff <= 1'b1;
                            firstAddr_ff <= recAddr_ff;
                        end
                    end
                    S_PAYLOAD:
                    begin
                        recLen_ff  <= recLen_ff - 8'h01;
                        recAddr_ff <= recAddr_ff + 16'h0001;
                        recSum_ff  <= recSum_ff + rxByte.data;
                    end
                    default:
                        recSum_ff <= recSum_ff;
                endcase
            end
            if (state_ff == S_SUM_WAIT && sumDone)
                sum_ff <= sumValue;
        end
    end

    // ram writes straight from the receive stream
    assign ramWrEn    = (state_ff == S_PAYLOAD) && rxValid && !rxErr;
    assign ramWr.addr = recAddr_ff;
    assign ramWr.data = rxByte.data;

    assign pwRdEn  = (state_ff == S_PWCNT_RD) || (state_ff == S_PWSTR_RD);
    assign pwRd.addr = (state_ff == S_PWCNT_RD) ? cntAddr_ff : cmpAddr_ff;

    assign errStart = (state_ff == S_ERR);
    assign sumStart = (state_ff == S_CKSUM) && rxValid && !rxErr
                      && recType_ff == srl_pkg::REC_END
                      && recSum_ff + rxByte.data == 8'h00;

    // baud switches in the same cycle that the transmitter accepts the echo
    assign baudLoad = (state_ff == S_ECHO_BAUD) && txReady;
    assign baudCode = latch_ff;

    // transmit mux; the record phase and halt send nothing
    always_comb
    begin
        txValid = 1'b0;
        txData  = 8'h00;
        unique case (state_ff)
            S_ECHO_MATCH:
            begin
                txValid = 1'b1;
                txData  = srl_pkg::MATCH_BYTE;
            end
            S_ECHO_BAUD, S_ECHO_CMD:
            begin
                txValid = 1'b1;
                txData  = latch_ff;
            end
            S_SUM_HI:
            begin
                txValid = 1'b1;
                txData  = sum_ff[15:8];
            end
            S_SUM_LO:
            begin
                txValid = 1'b1;
                txData  = sum_ff[7:0];
            end
            S_ERR:
            begin
                txValid = errTxValid;
                txData  = errTxData;
            end
            default:
            begin
                txValid = 1'b0;
                txData  = 8'h00;
            end
        endcase
    end

    assign jumpValid = (state_ff == S_JUMP);
    assign jumpAddr  = firstAddr_ff;
    assign halted    = (state_ff == S_HALT);
endmodule
`default_nettype wire

// [logic/srl_pkg.sv]
// shared constants and types of the serial boot loader command handler
package srl_pkg;
    localparam logic [7:0] MATCH_BYTE    = 8'h5A;
    localparam logic [7:0] CMD_FLASH     = 8'h30;
    localparam logic [7:0] CMD_RAMLOAD   = 8'h60;
    localparam logic [7:0] CMD_SUMOUT    = 8'h90;
    localparam logic [7:0] CMD_PRODID    = 8'hC0;
    localparam logic [7:0] ERR_OVERRUN   = 8'hA1;
    localparam logic [7:0] ERR_FRAMING   = 8'hA3;
    localparam logic [7:0] ERR_BAUD      = 8'h62;
    localparam logic [7:0] ERR_COMMAND   = 8'h63;
    localparam logic [7:0] START_MARK    = 8'h3A;
    localparam logic [7:0] ERASED_BYTE   = 8'hFF;
    localparam logic [7:0] REC_DATA      = 8'h00;
    localparam logic [7:0] REC_END       = 8'h01;
    localparam logic [1:0] ERR_REPEAT    = 2'd3;
    localparam int         NUM_BAUD      = 5;
    localparam logic [7:0] BAUD_CODES [NUM_BAUD] = '{8'h28, 8'h18, 8'h07, 8'h06, 8'h04};

    // one received byte with its line status
    typedef struct packed {
        logic [7:0] data;
        logic       overrun;
        logic       framing;
    } srl_rx_s;

    // one byte write into program ram
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } srl_ram_wr_s;

    // password store lookup request
    typedef struct packed {
        logic [15:0] addr;
    } srl_rd_s;
endpackage

// [logic/srl_err_sender.sv]
// sends an error code three times, reporting done as the third is accepted
`timescale 1ns/100ps
`default_nettype none
module srl_err_sender
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // request
    input  wire logic       start,
    input  wire logic [7:0] code,
    // transmitter
    output logic            txValid,
    output logic [7:0]      txData,
    input  wire logic       txReady,
    // status
    output logic            done
);
    logic [1:0] sentCnt_ff;
    logic       busy_ff;
    logic [7:0] code_ff;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            busy_ff    <= 1'b0;
            sentCnt_ff <= 2'd0;
            code_ff    <= 8'h00;
        end
        else if (start && !busy_ff)
        begin
            busy_ff    <= 1'b1;
            sentCnt_ff <= 2'd0;
            code_ff    <= code;
        end
        else if (busy_ff && txReady)
        begin
            sentCnt_ff <= sentCnt_ff + 2'd1;
            if (sentCnt_ff == srl_pkg::ERR_REPEAT - 2'd1)
                busy_ff <= 1'b0;
        end
    end

    assign txValid = busy_ff;
    assign txData  = code_ff;
    assign done    = busy_ff && txReady && (sentCnt_ff == srl_pkg::ERR_REPEAT - 2'd1);
endmodule
`default_nettype wire

// [verification/srl_boot_loader_monitor.sv]
// port checker for the serial boot command handler
`timescale 1ns/100ps
`default_nettype none
module srl_boot_loader_monitor
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // observed ports
    input wire logic       txValid,
    input wire logic [7:0] txData,
    input wire logic       txReady,
    input wire logic       baudLoad,
    input wire logic [7:0] baudCode,
    input wire logic       ramWrEn,
    input wire logic       sumStart,
    input wire logic       sumDone,
    input wire logic       jumpValid,
    input wire logic       halted
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_halt_is_quiet: assert property (halted |-> !txValid && !ramWrEn && !sumStart)
        else $error("activity while halted");
    a_halt_is_sticky: assert property (halted |=> halted)
        else $error("halt left without reset");
    a_tx_offer_held: assert property (txValid && !txReady |=> txValid && $stable(txData))
        else $error("offered byte dropped or changed");
    a_baud_after_echo: assert property (baudLoad |-> txValid && txReady && txData == baudCode)
        else $error("baud load not at echo acceptance");
    a_baud_one_pulse: assert property (baudLoad |=> !baudLoad)
        else $error("baud load longer than one cycle");
    a_sum_answered: assert property (sumDone |=> txValid)
        else $error("sum not offered after sum done");
    a_sum_single: assert property (sumStart |=> !sumStart [*8])
        else $error("sum start repeated");
    a_jump_then_halt: assert property (jumpValid |=> halted && !jumpValid)
        else $error("jump not followed by halt");
    a_record_silent: assert property (ramWrEn |-> !txValid && !halted)
        else $error("transmit during record phase");
endmodule

bind srl_boot_loader srl_boot_loader_monitor u_mon
(
    .clk       (clk),
    .rst_n     (rst_n),
    .txValid   (txValid),
    .txData    (txData),
    .txReady   (txReady),
    .baudLoad  (baudLoad),
    .baudCode  (baudCode),
    .ramWrEn   (ramWrEn),
    .sumStart  (sumStart),
    .sumDone   (sumDone),
    .jumpValid (jumpValid),
    .halted    (halted)
);
`default_nettype wire

// [verification/srl_far_model.sv]
// far side model: transmitter pacing, password store, sum engine
`timescale 1ns/100ps
`default_nettype none
module srl_far_model
#(
    parameter logic [15:0] SUM = 16'hC35A
)
(
    // clock and reset
    input wire logic             clk,
    input wire logic             rst_n,
    // pacing choice
    input wire logic             slow,
    // transmitter
    input wire logic             txValid,
    output logic                 txReady,
    // password store
    input wire logic             pwRdEn,
    input wire srl_pkg::srl_rd_s pwRd,
    output logic [7:0]           pwRdData,
    // sum engine
    input wire logic             sumStart,
    output logic                 sumDone,
    output logic [15:0]          sumValue
);
    logic [1:0] pace_ff;
    logic [2:0] sumCnt_ff;

    // slow mode accepts a byte only one cycle in four, like a busy shifter
    assign txReady = txValid && (!slow || pace_ff == 2'h3);
    assign sumDone = sumCnt_ff == 3'h1;
    // value stale outside the pulse, so a late sample shows up
    assign sumValue = sumDone ? SUM : ~SUM ^ {14'h0000, pace_ff};

    always_ff @(posedge clk)
    begin
        pace_ff <= rst_n ? pace_ff + 2'h1 : 2'h0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sumCnt_ff <= 3'h0;
        else if (sumStart)
            sumCnt_ff <= slow ? 3'h6 : 3'h2;
        else if (sumCnt_ff != 3'h0)
            sumCnt_ff <= sumCnt_ff - 3'h1;
    end

    // count at 0010 is two, compare bytes are address plus 40
    always_ff @(posedge clk)
    begin
        if (pwRdEn)
            pwRdData <= (pwRd.addr[7:0] == 8'h10) ? 8'h02 : pwRd.addr[7:0] + 8'h40;
        else
            pwRdData <= ~pwRdData;
    end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the serial boot command handler
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [15:0] SUMV = 16'hC35A;
    logic                 clk, rst_n, rxValid, txValid, txReady, baudLoad, pwRdEn;
    logic                 pwBlank, securityOn, ramWrEn, sumStart, sumDone;
    logic                 jumpValid, halted, slow;
    logic [7:0]           txData, baudCode, pwRdData;
    logic [15:0]          sumValue, jumpAddr;
    srl_pkg::srl_rx_s     rxByte;
    srl_pkg::srl_rd_s     pwRd;
    srl_pkg::srl_ram_wr_s ramWr;
    int                   fails, checksDone, seed, jumps;
    logic [7:0]           txQ[$];
    srl_pkg::srl_ram_wr_s wrQ[$];
    logic [15:0]          ra[2];
    logic [7:0]           rd[2];
    logic [7:0]           pa[4] = '{8'h00, 8'h10, 8'h00, 8'h20};
    logic [7:0]           cmds[3] = '{srl_pkg::CMD_FLASH, srl_pkg::CMD_SUMOUT, srl_pkg::CMD_PRODID};
    logic [7:0]           eb[4] = '{8'h55, 8'h28, 8'h60, 8'h77};
    logic [1:0]           ee[4] = '{2'b00, 2'b01, 2'b10, 2'b00};
    logic [7:0]           ec[4] = '{srl_pkg::ERR_BAUD, srl_pkg::ERR_FRAMING,
                                    srl_pkg::ERR_OVERRUN, srl_pkg::ERR_COMMAND};

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    srl_boot_loader u_dut (.clk(clk), .rst_n(rst_n), .rxValid(rxValid), .rxByte(rxByte),
        .txValid(txValid), .txData(txData), .txReady(txReady), .baudLoad(baudLoad),
        .baudCode(baudCode), .pwRdEn(pwRdEn), .pwRd(pwRd), .pwRdData(pwRdData),
        .pwBlank(pwBlank), .securityOn(securityOn), .ramWrEn(ramWrEn), .ramWr(ramWr),
        .sumStart(sumStart), .sumDone(sumDone), .sumValue(sumValue),
        .jumpValid(jumpValid), .jumpAddr(jumpAddr), .halted(halted));

    srl_far_model #(.SUM(SUMV)) u_far (.clk(clk), .rst_n(rst_n), .slow(slow),
        .txValid(txValid), .txReady(txReady), .pwRdEn(pwRdEn), .pwRd(pwRd),
        .pwRdData(pwRdData), .sumStart(sumStart), .sumDone(sumDone), .sumValue(sumValue));

    always @(posedge clk)
    begin
        if (txValid && txReady)
            txQ.push_back(txData);
        if (ramWrEn)
            wrQ.push_back(ramWr);
        if (jumpValid)
            jumps++;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        if (fails == 0 && checksDone > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic reset_dut;
        rst_n = 1'b0;
        slow = 1'($random(seed));
        repeat (5) @(negedge clk);
        txQ.delete();
        wrQ.delete();
        jumps = 0;
        rst_n = 1'b1;
    endtask

    // drains any echo and spaces bytes past the password store reads
    task automatic send(input logic [7:0] d, input logic [1:0] err = 2'b00);
        int n;
        n = 0;
        while (txValid === 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        rxByte = {d, err};
        rxValid = 1'b1;
        @(negedge clk);
        rxValid = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic expect_tx(input logic [7:0] d);
        int n;
        n = 0;
        while (txQ.size() == 0 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        if (txQ.size() == 0)
            chk(16'h0100, {8'h00, d});
        else
            chk({8'h00, txQ.pop_front()}, {8'h00, d});
    endtask

    task automatic head(input logic [7:0] b, input logic [7:0] c);
        send(srl_pkg::MATCH_BYTE);
        expect_tx(srl_pkg::MATCH_BYTE);
        send(b);
        expect_tx(b);
        send(c);
        expect_tx(c);
    endtask

    // one payload byte at most; bad flips the checksum's low bit
    task automatic record(input logic [7:0] t, input logic [15:0] a,
                          input logic [7:0] d, input logic bad);
        logic [7:0] s, ln;
        ln = (t == srl_pkg::REC_DATA) ? 8'h01 : 8'h00;
        s = ln + a[15:8] + a[7:0] + t + (ln[0] ? d : 8'h00);
        send(srl_pkg::START_MARK);
        send(ln);
        send(a[15:8]);
        send(a[7:0]);
        send(t);
        if (ln[0])
            send(d);
        send((8'h00 - s) ^ {7'h00, bad});
    endtask

    task automatic silent;
        repeat (20) @(negedge clk);
        chk({15'h0000, halted}, 16'h0001);
        send(srl_pkg::MATCH_BYTE);
        repeat (5) @(negedge clk);
        chk(16'(txQ.size()), 16'h0000);
    endtask

    initial
    begin
        seed = 32'h1d8c;
        rst_n = 1'b0;
        rxValid = 1'b0;
        rxByte = '0;
        pwBlank = 1'b1;
        securityOn = 1'b0;
        slow = 1'b0;
        for (int i = 0; i < srl_pkg::NUM_BAUD; i++)
        begin
            reset_dut();
            head(srl_pkg::BAUD_CODES[i], cmds[i % 3]);
            send(srl_pkg::CMD_RAMLOAD);
            expect_tx(srl_pkg::CMD_RAMLOAD);
        end
        for (int k = 0; k < 2; k++)
        begin
            reset_dut();
            pwBlank = (k == 0);
            head(8'h28, srl_pkg::CMD_RAMLOAD);
            foreach (pa[p])
                send(pa[p]);
            if (k == 1)
            begin
                send(8'h60);
                send(8'h61);
            end
            for (int w = 0; w < 2; w++)
            begin
                ra[w] = 16'($random(seed));
                rd[w] = 8'($random(seed));
                send(8'($random(seed)) | 8'h80);
                record(srl_pkg::REC_DATA, ra[w], rd[w], 1'b0);
            end
            record(srl_pkg::REC_END, 16'h0000, 8'h00, 1'b0);
            expect_tx(SUMV[15:8]);
            expect_tx(SUMV[7:0]);
            repeat (10) @(negedge clk);
            chk(16'(jumps), 16'h0001);
            chk(jumpAddr, ra[0]);
            chk(16'(wrQ.size()), 16'h0002);
            foreach (wrQ[w])
            begin
                chk(wrQ[w].addr, ra[w]);
                chk({8'h00, wrQ[w].data}, {8'h00, rd[w]});
            end
            chk({15'h0000, halted}, 16'h0001);
        end
        for (int j = 0; j < 4; j++)
        begin
            reset_dut();
            send(srl_pkg::MATCH_BYTE);
            expect_tx(srl_pkg::MATCH_BYTE);
            if (j > 1)
            begin
                send(8'h28);
                expect_tx(8'h28);
            end
            send(eb[j], ee[j]);
            repeat (3) expect_tx(ec[j]);
            silent();
        end
        for (int j = 0; j < 5; j++)
        begin
            reset_dut();
            pwBlank = (j == 1 || j == 2);
            securityOn = (j == 3);
            head(8'h28, srl_pkg::CMD_RAMLOAD);
            if (j == 1)
                send(8'h00, 2'b01);
            else
                foreach (pa[p])
                    send((j == 4 && p == 1) ? 8'hBF : pa[p]);
            if (j == 0)
            begin
                send(8'h60);
                send(8'h77);
            end
            if (j == 2)
                record(srl_pkg::REC_DATA, 16'h0040, 8'h5C, 1'b1);
            silent();
        end
        print_verdict();
    end
    // whole run needs well under this many cycles
    initial
    begin
        #(8 * 60000);
        fails++;
        print_verdict();
    end
endmodule
`default_nettype wire
